// ### verilog/link_pkg.sv
package link_pkg;

    // ****************************************
    // Clock and character timing
    // ****************************************
    localparam int CLK_HZ = 200_000_000;
    localparam int BAUD = 19200;
    localparam int OVERSAMPLE = 16;
    localparam int TICK_DIV = CLK_HZ / (BAUD * OVERSAMPLE);
    localparam int DIV_W = 10;
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SUB_HALF = 4'h7;
    localparam logic [2:0] DATA_LAST = 3'h7;
    localparam logic [3:0] TX_BITS_LAST = 4'h9;
    localparam logic [9:0] TX_IDLE = 10'h3FF;

    // ****************************************
    // Link timeouts
    // ****************************************
    localparam int TIMER_W = 28;
    localparam int GAP_MS = 10;
    localparam int REPLY_MS = 500;
    localparam int ID_REPLY_MS = 50;
    localparam int IDLE_MS = 1000;
    localparam int GAP_CYCLES = CLK_HZ / 1000 * GAP_MS;
    localparam int REPLY_CYCLES = CLK_HZ / 1000 * REPLY_MS;
    localparam int ID_REPLY_CYCLES = CLK_HZ / 1000 * ID_REPLY_MS;
    localparam int IDLE_CYCLES = CLK_HZ / 1000 * IDLE_MS;

    // ****************************************
    // Frame layout and codes
    // ****************************************
    localparam logic [7:0] BYTE_START = 8'h5A;
    localparam logic [7:0] FRAME_MIN = 8'h04;
    localparam logic [7:0] FRAME_MAX = 8'h80;
    localparam logic [7:0] FRAME_OVERHEAD = 8'h03;
    localparam logic [7:0] REPLY_OVERHEAD = 8'h04;
    localparam logic [6:0] REPLY_DATA_MAX = 7'h7C;
    localparam logic [7:0] IDX_LEN = 8'h01;
    localparam logic [7:0] IDX_CODE = 8'h02;
    localparam logic [7:0] IDX_PAYLOAD = 8'h02;
    localparam logic [7:0] IDX_DATA = 8'h03;
    localparam logic [7:0] CMD_SLEEP = 8'h00;
    localparam logic [7:0] CMD_ID = 8'h01;
    localparam logic [7:0] CODE_ACK = 8'h06;
    localparam logic [7:0] CODE_NAK = 8'h15;
    localparam int MEM_DEPTH = 128;
    localparam int ADDR_W = 7;

    typedef enum logic [3:0] {
        LINK_SLEEP = 4'h1,
        LINK_LISTEN = 4'h2,
        LINK_WAIT = 4'h4,
        LINK_SEND = 4'h8
    } link_state_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;

    typedef enum logic [2:0] {
        PARSE_HUNT = 3'h1,
        PARSE_LENGTH = 3'h2,
        PARSE_BODY = 3'h4
    } parse_state_t;

endpackage

// ### verilog/frame_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface frame_mem_if;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
        input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
        output rd_data);
endinterface

`default_nettype wire

// ### verilog/frame_mem.sv
`timescale 1ns/1ps
`default_nettype none

module frame_mem (
    input wire logic mclk,
    frame_mem_if.store bus
);
    logic [7:0] cells [link_pkg::MEM_DEPTH];

    // Read data is registered so the user sees it one cycle after the address
    always_ff @(posedge mclk) begin
        if (bus.wr_en) begin
            cells[bus.wr_addr] <= bus.wr_data;
        end
        bus.rd_data <= cells[bus.rd_addr];
    end
endmodule

`default_nettype wire

// ### verilog/sensor_link_frame_layer.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - 19200 baud, 8 data, 1 stop, no parity
// - Data bits go out LSB first
// - Transmit line rests high when idle
// - Master starts; device replies only to valid frames
// - Falling edge of shared reset gives event
// - Shared reset only pulled low, open-drain
// - Receive falling edge wakes the device
// - Frame: start, length, payload, checksum
// - Frame at most 128 bytes
// - Start byte is 5A hex
// - Length counts every byte of frame
// - Checksum is XOR of earlier bytes
// - Inter-byte gap at most 10 ms
// - Reply begins within 500 ms
// - Bad or partial frame: drop silently
// - Identification query answered within 50 ms
// - Idle over 1000 ms returns to sleep
// - Sleep command zero: acknowledge, then sleep
// - Reply payload starts with ACK or NAK
module sensor_link_frame_layer #(
    parameter int TICK_DIV = link_pkg::TICK_DIV,
    parameter int GAP_CYCLES = link_pkg::GAP_CYCLES,
    parameter int REPLY_CYCLES = link_pkg::REPLY_CYCLES,
    parameter int ID_REPLY_CYCLES = link_pkg::ID_REPLY_CYCLES,
    parameter int IDLE_CYCLES = link_pkg::IDLE_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic rx_line,
    output logic tx_line,
    input wire logic rst_line_in,
    output logic rst_line_out,
    output logic rst_line_oe,
    input wire logic rst_pull_request,
    output logic zero_event,
    output logic break_seen,
    output logic asleep,
    output logic cmd_valid,
    output logic [6:0] cmd_len,
    input wire logic [6:0] cmd_addr,
    output logic [7:0] cmd_data,
    input wire logic reply_start,
    input wire logic reply_ack,
    input wire logic [6:0] reply_len,
    input wire logic reply_valid,
    input wire logic [7:0] reply_data,
    output logic reply_ready
);
    localparam int TW = link_pkg::TIMER_W;

    // ****************************************
    // Receive character engine
    // ****************************************
    logic [link_pkg::DIV_W-1:0] rx_div;
    link_pkg::rx_state_t rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_armed;
    logic rx_prev;
    logic byte_valid;
    logic [7:0] byte_data;

    wire rx_tick = rx_div == link_pkg::DIV_W'(TICK_DIV - 1);
    wire rx_sub_end = rx_sub == link_pkg::SUB_LAST;
    wire rx_fall = rx_prev && !rx_line;

    always_ff @(posedge mclk) begin
        if (reset || rx_tick) begin
            rx_div <= '0;
        end else begin
            rx_div <= rx_div + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_line;
        end
    end

    // A break keeps the line low past its stop bit; rearming only after a
    // high level stops the tail of a break being decoded as a stray byte.
    always_ff @(posedge mclk) begin
        byte_valid <= 1'b0;
        break_seen <= 1'b0;
        if (reset) begin
            rx_st <= link_pkg::RX_IDLE;
            rx_sub <= '0;
            rx_bit <= '0;
            rx_shift <= '0;
            rx_armed <= 1'b0;
            byte_data <= '0;
        end else if (rx_tick) begin
            case (rx_st)
                link_pkg::RX_IDLE: begin
                    rx_sub <= '0;
                    if (rx_line) begin
                        rx_armed <= 1'b1;
                    end else if (rx_armed) begin
                        rx_st <= link_pkg::RX_START;
                    end
                end
                link_pkg::RX_START: begin
                    if (rx_line) begin
                        rx_st <= link_pkg::RX_IDLE;
                    end else if (rx_sub == link_pkg::SUB_HALF) begin
                        rx_st <= link_pkg::RX_DATA;
                        rx_sub <= '0;
                        rx_bit <= '0;
                    end else begin
                        rx_sub <= rx_sub + 1'b1;
                    end
                end
                link_pkg::RX_DATA: begin
                    rx_sub <= rx_sub + 1'b1;
                    if (rx_sub_end) begin
                        rx_shift <= {rx_line, rx_shift[7:1]};
                        rx_bit <= rx_bit + 1'b1;
                        if (rx_bit == link_pkg::DATA_LAST) begin
                            rx_st <= link_pkg::RX_STOP;
                        end
                    end
                end
                link_pkg::RX_STOP: begin
                    rx_sub <= rx_sub + 1'b1;
                    if (rx_sub_end) begin
                        rx_st <= link_pkg::RX_IDLE;
                        rx_armed <= 1'b0;
                        byte_valid <= rx_line;
                        byte_data <= rx_shift;
                        break_seen <= !rx_line && rx_shift == '0;
                    end
                end
                default: begin
                    rx_st <= link_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Link state and frame parser
    // ****************************************
    link_pkg::link_state_t link;
    link_pkg::parse_state_t p_st;
    logic [7:0] p_idx;
    logic [7:0] p_len;
    logic [7:0] p_xor;
    logic [7:0] p_first;
    logic [TW-1:0] gap_cnt;
    logic [TW-1:0] idle_cnt;
    logic [TW-1:0] wait_cnt;
    logic [TW-1:0] wait_limit;
    logic frame_good;

    wire listening = link == link_pkg::LINK_LISTEN;
    wire got_byte = listening && byte_valid;
    wire len_ok = byte_data >= link_pkg::FRAME_MIN && byte_data <= link_pkg::FRAME_MAX;
    wire at_chk = p_idx == p_len - 8'h01;
    wire gap_over = gap_cnt == TW'(GAP_CYCLES);
    wire in_frame = p_st != link_pkg::PARSE_HUNT;
    wire is_sleep_cmd = p_len == link_pkg::FRAME_MIN && p_first == link_pkg::CMD_SLEEP;

    frame_mem_if mem ();

    assign mem.wr_en = got_byte && p_st == link_pkg::PARSE_BODY && !at_chk;
    assign mem.wr_addr = link_pkg::ADDR_W'(p_idx - link_pkg::IDX_PAYLOAD);
    assign mem.wr_data = byte_data;
    assign mem.rd_addr = cmd_addr;
    assign cmd_data = mem.rd_data;

    frame_mem store_i (
        .mclk(mclk),
        .bus(mem)
    );

    // Only bytes heard while listening count; the link is half duplex
    always_ff @(posedge mclk) begin
        frame_good <= 1'b0;
        if (reset || !listening || break_seen || (in_frame && gap_over)) begin
            p_st <= link_pkg::PARSE_HUNT;
        end else if (got_byte) begin
            case (p_st)
                link_pkg::PARSE_HUNT: begin
                    if (byte_data == link_pkg::BYTE_START) begin
                        p_st <= link_pkg::PARSE_LENGTH;
                        p_xor <= byte_data;
                        p_idx <= link_pkg::IDX_LEN;
                    end
                end
                link_pkg::PARSE_LENGTH: begin
                    p_st <= len_ok ? link_pkg::PARSE_BODY : link_pkg::PARSE_HUNT;
                    p_len <= byte_data;
                    p_xor <= p_xor ^ byte_data;
                    p_idx <= link_pkg::IDX_PAYLOAD;
                end
                link_pkg::PARSE_BODY: begin
                    if (at_chk) begin
                        p_st <= link_pkg::PARSE_HUNT;
                        frame_good <= p_xor == byte_data;
                    end else begin
                        if (p_idx == link_pkg::IDX_PAYLOAD) begin
                            p_first <= byte_data;
                        end
                        p_xor <= p_xor ^ byte_data;
                        p_idx <= p_idx + 8'h01;
                    end
                end
                default: begin
                    p_st <= link_pkg::PARSE_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || !in_frame || got_byte) begin
            gap_cnt <= '0;
        end else if (!gap_over) begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    // Idle time counts only while the line rests high and no frame is open
    always_ff @(posedge mclk) begin
        if (reset || !listening || !rx_line || in_frame) begin
            idle_cnt <= '0;
        end else begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // ****************************************
    // Transmit sequencer and character engine
    // ****************************************
    logic [7:0] t_idx;
    logic [7:0] t_total;
    logic [7:0] t_xor;
    logic t_ack;
    logic sleep_after;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_bitn;
    logic [3:0] tx_sub;
    logic [link_pkg::DIV_W-1:0] tx_div;

    wire sending = link == link_pkg::LINK_SEND;
    wire data_phase = t_idx >= link_pkg::IDX_DATA && t_idx < t_total - 8'h01;
    wire loaded_all = t_idx == t_total;
    wire tx_load = sending && !tx_busy && !loaded_all && (!data_phase || reply_valid);
    wire send_done = sending && loaded_all && !tx_busy;
    wire tx_tick = tx_div == link_pkg::DIV_W'(TICK_DIV - 1);
    wire [6:0] reply_clamped = reply_len > link_pkg::REPLY_DATA_MAX ?
        link_pkg::REPLY_DATA_MAX : reply_len;
    wire [7:0] code_byte = t_ack ? link_pkg::CODE_ACK : link_pkg::CODE_NAK;
    wire [7:0] tx_byte = t_idx == '0 ? link_pkg::BYTE_START :
        t_idx == link_pkg::IDX_LEN ? t_total :
        t_idx == link_pkg::IDX_CODE ? code_byte :
        data_phase ? reply_data : t_xor;

    assign reply_ready = sending && !tx_busy && data_phase;
    assign tx_line = tx_sh[0];

    always_ff @(posedge mclk) begin
        if (reset || tx_load || tx_tick) begin
            tx_div <= '0;
        end else begin
            tx_div <= tx_div + 1'b1;
        end
    end

    // Shifting in ones means the line is back at mark as soon as a frame ends
    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_busy <= 1'b0;
            tx_sh <= link_pkg::TX_IDLE;
            tx_bitn <= '0;
            tx_sub <= '0;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            tx_sh <= {1'b1, tx_byte, 1'b0};
            tx_bitn <= '0;
            tx_sub <= '0;
        end else if (tx_busy && tx_tick) begin
            tx_sub <= tx_sub + 1'b1;
            if (tx_sub == link_pkg::SUB_LAST) begin
                tx_sh <= {1'b1, tx_sh[9:1]};
                tx_bitn <= tx_bitn + 1'b1;
                tx_busy <= tx_bitn != link_pkg::TX_BITS_LAST;
            end
        end
    end

    // ****************************************
    // Session control
    // ****************************************
    always_ff @(posedge mclk) begin
        cmd_valid <= 1'b0;
        if (reset) begin
            link <= link_pkg::LINK_SLEEP;
            t_idx <= '0;
            t_total <= '0;
            t_xor <= '0;
            t_ack <= 1'b0;
            sleep_after <= 1'b0;
            wait_cnt <= '0;
            wait_limit <= '0;
            cmd_len <= '0;
        end else begin
            case (link)
                link_pkg::LINK_SLEEP: begin
                    if (rx_fall) begin
                        link <= link_pkg::LINK_LISTEN;
                    end
                end
                link_pkg::LINK_LISTEN: begin
                    t_idx <= '0;
                    t_xor <= '0;
                    wait_cnt <= '0;
                    if (frame_good && is_sleep_cmd) begin
                        link <= link_pkg::LINK_SEND;
                        t_ack <= 1'b1;
                        t_total <= link_pkg::REPLY_OVERHEAD;
                        sleep_after <= 1'b1;
                    end else if (frame_good) begin
                        link <= link_pkg::LINK_WAIT;
                        cmd_valid <= 1'b1;
                        cmd_len <= link_pkg::ADDR_W'(p_len - link_pkg::FRAME_OVERHEAD);
                        sleep_after <= 1'b0;
                        wait_limit <= p_first == link_pkg::CMD_ID ?
                            TW'(ID_REPLY_CYCLES - 1) : TW'(REPLY_CYCLES - 1);
                    end else if (idle_cnt == TW'(IDLE_CYCLES)) begin
                        link <= link_pkg::LINK_SLEEP;
                    end
                end
                link_pkg::LINK_WAIT: begin
                    wait_cnt <= wait_cnt + 1'b1;
                    if (reply_start) begin
                        link <= link_pkg::LINK_SEND;
                        t_ack <= reply_ack;
                        t_total <= {1'b0, reply_clamped} + link_pkg::REPLY_OVERHEAD;
                    end else if (wait_cnt == wait_limit) begin
                        // Silence past the deadline would read as no device
                        link <= link_pkg::LINK_SEND;
                        t_ack <= 1'b0;
                        t_total <= link_pkg::REPLY_OVERHEAD;
                    end
                end
                link_pkg::LINK_SEND: begin
                    if (tx_load) begin
                        t_idx <= t_idx + 8'h01;
                        t_xor <= t_xor ^ tx_byte;
                    end
                    if (send_done) begin
                        link <= sleep_after ? link_pkg::LINK_SLEEP : link_pkg::LINK_LISTEN;
                    end
                end
                default: begin
                    link <= link_pkg::LINK_SLEEP;
                end
            endcase
        end
    end

    assign asleep = link == link_pkg::LINK_SLEEP;

    // ****************************************
    // Shared reset line
    // ****************************************
    logic rst_prev;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rst_prev <= 1'b1;
            zero_event <= 1'b0;
            rst_line_oe <= 1'b0;
        end else begin
            rst_prev <= rst_line_in;
            zero_event <= rst_prev && !rst_line_in;
            rst_line_oe <= rst_pull_request;
        end
    end

    // Never driven high: the master's pull-up owns the high level
    assign rst_line_out = 1'b0;
endmodule

`default_nettype wire

// ### dv/link_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Master node model: wakes the device, sends frames, collects replies
// ****************************************
module link_master_model #(
    parameter int BIT = 10416
) (
    input wire logic mclk,
    output logic to_dev,
    input wire logic from_dev
);
    logic [7:0] rxq[$];
    logic [7:0] got;
    int frame_err = 0;

    initial to_dev = 1'b1;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] sh;
        sh = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            to_dev = sh[i];
            repeat (BIT) @(negedge mclk);
        end
    endtask

    // Every break bit is zero so no stray character can be decoded
    task automatic send_break();
        to_dev = 1'b0;
        repeat (15 * BIT) @(negedge mclk);
        to_dev = 1'b1;
        repeat (39 * BIT) @(negedge mclk);
    endtask

    // Mid-bit sampling of the device's line; stop level is judged too
    always begin
        @(negedge from_dev);
        repeat (BIT + BIT / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            got[i] = from_dev;
            repeat (BIT) @(posedge mclk);
        end
        if (from_dev !== 1'b1) frame_err++;
        rxq.push_back(got);
    end
endmodule

`default_nettype wire

// ### dv/sensor_link_frame_layer_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port-level checker
// ****************************************
module sensor_link_frame_layer_chk #(
    parameter int GAP_CYCLES = 2000,
    parameter int REPLY_CYCLES = 20000,
    parameter int ID_REPLY_CYCLES = 1000,
    parameter int IDLE_CYCLES = 500000
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic rx_line,
    input wire logic tx_line,
    input wire logic rst_line_in,
    input wire logic rst_line_out,
    input wire logic rst_line_oe,
    input wire logic rst_pull_request,
    input wire logic zero_event,
    input wire logic break_seen,
    input wire logic asleep,
    input wire logic cmd_valid,
    input wire logic reply_ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // Cycles from a valid frame to the first reply edge
    logic pending;
    int wait_cnt;
    always_ff @(posedge mclk) begin
        if (reset || !tx_line) begin
            pending <= 1'b0;
            wait_cnt <= 0;
        end else if (cmd_valid) begin
            pending <= 1'b1;
        end else if (pending) begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    rst_drive_low_a: assert property (rst_line_out == 1'b0)
        else $error("shared reset driven high");
    rst_oe_follow_a: assert property (!$past(reset) |-> rst_line_oe == $past(rst_pull_request))
        else $error("pull enable does not follow request");
    zero_edge_a: assert property ($fell(rst_line_in) && !$past(reset) |=> zero_event)
        else $error("no zero event after reset line fall");
    tx_idle_high_a: assert property (asleep |-> tx_line)
        else $error("transmit line low while asleep");
    tx_after_frame_a: assert property ($fell(tx_line) |-> !asleep && !$past(asleep))
        else $error("transmit without an open session");
    wake_on_fall_a: assert property (asleep && $fell(rx_line) |-> ##[1:2] !asleep)
        else $error("receive fall did not wake");
    cmd_one_pulse_a: assert property (cmd_valid |-> !asleep ##1 !cmd_valid)
        else $error("command strobe malformed");
    break_one_pulse_a: assert property (break_seen |=> !break_seen)
        else $error("break flag longer than one cycle");
    reply_deadline_a: assert property (wait_cnt <= REPLY_CYCLES + 8)
        else $error("reply started too late");
    ready_awake_a: assert property (reply_ready |-> !asleep)
        else $error("reply ready while asleep");

    cmd_seen_c: cover property (cmd_valid);
    break_seen_c: cover property (break_seen);
    zero_seen_c: cover property (zero_event);
    sleep_again_c: cover property ($rose(asleep));
endmodule

bind sensor_link_frame_layer sensor_link_frame_layer_chk #(
    .GAP_CYCLES(GAP_CYCLES), .REPLY_CYCLES(REPLY_CYCLES),
    .ID_REPLY_CYCLES(ID_REPLY_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)
) chk (
    .mclk(mclk), .reset(reset), .rx_line(rx_line), .tx_line(tx_line),
    .rst_line_in(rst_line_in), .rst_line_out(rst_line_out), .rst_line_oe(rst_line_oe),
    .rst_pull_request(rst_pull_request), .zero_event(zero_event), .break_seen(break_seen),
    .asleep(asleep), .cmd_valid(cmd_valid), .reply_ready(reply_ready)
);

`default_nettype wire

// ### dv/sensor_link_frame_layer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sensor_link_frame_layer_tb;
    localparam int BIT = 64; // Scaled bit time keeps the run short
    localparam int REPLY_T = 5000;
    localparam int ID_T = 1000;
    logic mclk = 1'b0, reset = 1'b1, rst_line_in = 1'b1, rst_pull_request = 1'b0;
    logic reply_start = 1'b0, reply_ack = 1'b0, reply_valid = 1'b0, tx_prev = 1'b1;
    logic [6:0] cmd_addr = 7'h00, reply_len = 7'h00, cmd_len;
    logic [7:0] reply_data = 8'h00, cmd_data;
    logic rx_line, tx_line, rst_line_out, rst_line_oe, zero_event, break_seen, asleep;
    logic cmd_valid, reply_ready;
    int err_total = 0, total_checks = 0, cycles = 0, n_cmd = 0, n_brk = 0, n_zero = 0;
    int t_cmd = 0, t_tx = 0, n0;

    always #2.5 mclk = ~mclk;

    sensor_link_frame_layer #(.TICK_DIV(BIT / 16), .GAP_CYCLES(2000), .REPLY_CYCLES(REPLY_T),
        .ID_REPLY_CYCLES(ID_T), .IDLE_CYCLES(20000)) dut (
        .mclk(mclk), .reset(reset), .rx_line(rx_line), .tx_line(tx_line),
        .rst_line_in(rst_line_in), .rst_line_out(rst_line_out), .rst_line_oe(rst_line_oe),
        .rst_pull_request(rst_pull_request), .zero_event(zero_event),
        .break_seen(break_seen), .asleep(asleep), .cmd_valid(cmd_valid),
        .cmd_len(cmd_len), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .reply_start(reply_start), .reply_ack(reply_ack), .reply_len(reply_len),
        .reply_valid(reply_valid), .reply_data(reply_data), .reply_ready(reply_ready));

    link_master_model #(.BIT(BIT)) mm (.mclk(mclk), .to_dev(rx_line), .from_dev(tx_line));

    // ****************************************
    // Event monitor and run limit
    // ****************************************
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        tx_prev <= tx_line;
        if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
        if (cmd_valid === 1'b1) t_cmd <= cycles;
        if (tx_line === 1'b0 && tx_prev === 1'b1 && t_tx < t_cmd) t_tx <= cycles;
        if (break_seen === 1'b1) n_brk <= n_brk + 1;
        if (zero_event === 1'b1) n_zero <= n_zero + 1;
        if (cycles == 100000) begin
            err_total++;
            final_report();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // A gap of 3000 cycles after byte gap_after breaks the inter-byte limit
    task automatic send_frame(input logic [7:0] f[4], input int gap_after);
        for (int i = 0; i < 4; i++) begin
            mm.send_byte(f[i]);
            if (i == gap_after) repeat (3000) @(negedge mclk);
        end
    endtask

    task automatic expect_frame(input logic [7:0] f[$]);
        for (int i = 0; i < 20 * BIT * f.size() && mm.rxq.size() < f.size(); i++)
            @(negedge mclk);
        for (int i = 0; i < f.size(); i++) begin
            check((mm.rxq.size() > 0) ? mm.rxq.pop_front() : 8'hXX, f[i]);
        end
        check(8'(mm.frame_err), 8'h00);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_line();
        check(asleep, 1'b1);
        rst_line_in = 1'b0;
        repeat (3) @(negedge mclk);
        check(8'(n_zero), 8'h01);
        rst_line_in = 1'b1;
        rst_pull_request = 1'b1;
        repeat (2) @(negedge mclk);
        check({rst_line_oe, rst_line_out}, 2'h2);
        rst_pull_request = 1'b0;
        repeat (2) @(negedge mclk);
        check(rst_line_oe, 1'b0);
        $display("reset line test done");
    endtask

    task automatic t_wake();
        n0 = n_brk;
        mm.send_break();
        check(n_brk > n0, 1'b1);
        check(asleep, 1'b0);
        $display("wake test done");
    endtask

    task automatic t_valid();
        n0 = n_cmd;
        send_frame('{8'h5A, 8'h04, 8'h02, 8'h5C}, 9);
        check(8'(n_cmd - n0), 8'h01);
        check(cmd_len, 7'h01);
        reply_start = 1'b1;
        reply_ack = 1'b1;
        reply_len = 7'h01;
        @(negedge mclk);
        reply_start = 1'b0;
        check(cmd_data, 8'h02);
        for (int i = 0; i < 40 * BIT && reply_ready !== 1'b1; i++) @(negedge mclk);
        reply_valid = 1'b1;
        reply_data = 8'hA5;
        @(negedge mclk);
        reply_valid = 1'b0;
        expect_frame('{8'h5A, 8'h05, 8'h06, 8'hA5, 8'hFC});
        $display("valid frame test done");
    endtask

    // A bad or gapped frame draws neither a command nor a reply
    task automatic t_silent(input logic [7:0] f[4], input int gap_after);
        n0 = n_cmd;
        send_frame(f, gap_after);
        repeat (2 * REPLY_T) @(negedge mclk);
        check(8'(n_cmd - n0), 8'h00);
        check(8'(mm.rxq.size()), 8'h00);
        $display("silent frame test done");
    endtask

    task automatic t_id();
        send_frame('{8'h5A, 8'h04, 8'h01, 8'h5F}, 9);
        expect_frame('{8'h5A, 8'h04, 8'h15, 8'h4B});
        check(t_tx - t_cmd <= ID_T + 20, 1'b1);
        $display("identification test done");
    endtask

    task automatic t_sleep();
        n0 = n_cmd;
        send_frame('{8'h5A, 8'h04, 8'h00, 8'h5E}, 9);
        expect_frame('{8'h5A, 8'h04, 8'h06, 8'h58});
        repeat (BIT) @(negedge mclk);
        check(asleep, 1'b1);
        check(8'(n_cmd - n0), 8'h00);
        $display("sleep command test done");
    endtask

    // A break wakes the device; 20000 idle cycles send it back to sleep
    task automatic t_idle();
        mm.send_break();
        check(asleep, 1'b0);
        repeat (20000) @(negedge mclk);
        check(asleep, 1'b1);
        $display("idle sleep test done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        repeat (2) @(negedge mclk);
        t_reset_line();
        t_wake();
        t_valid();
        t_silent('{8'h5A, 8'h04, 8'h02, 8'h00}, 9);
        t_silent('{8'h5A, 8'h04, 8'h02, 8'h5C}, 1);
        t_id();
        t_sleep();
        t_idle();
        final_report();
    end
endmodule

`default_nettype wire
